/* File: motor_status_params.svh */
// offsets, field positions and reset values of the motor system status bank
`ifndef MOTOR_STATUS_PARAMS_SVH
`define MOTOR_STATUS_PARAMS_SVH
`define ADDR_W              8
`define OFS_ALGORITHM_STATUS 8'he4
`define OFS_MEASURED_MOTOR  8'he6
`define OFS_ESTIMATION      8'he8
`define RESET_WORD          32'h0000_0000
`define APPLIED_VOLT_LSB    16
`define SPEED_CMD_LSB       4
`define LOAD_DONE_BIT       3
`define HOST_CTRL_BIT       2
`define RES_LSB             24
`define BEMF_LSB            16
`define IND_LSB             8
`define EST_FLAGS_LSB       28
`define EST_RATE_LSB        24
`define ALGO_LIVE_MASK      32'hffff_fffc
`define MOTOR_LIVE_MASK     32'hffff_ff00
`define EST_LIVE_MASK       32'hff00_0000
`endif

/* File: motor_status_pkg.sv */
// types shared by the motor system status bank
package motor_status_pkg;
   typedef struct packed {
      logic [15:0] applied_voltage_magnitude;
      logic [11:0] speed_command;
      logic        startup_load_complete;
      logic        host_control_allowed;
   } algorithm_status_s;

   typedef struct packed {
      logic [7:0] winding_resistance;
      logic [7:0] back_emf_constant;
      logic [7:0] winding_inductance;
   } measured_motor_values_s;

   typedef struct packed {
      logic       resistance_done;
      logic       inductance_done;
      logic       back_emf_done;
      logic       mechanical_done;
      logic [3:0] estimation_switching_rate;
   } estimation_status_s;

   typedef struct packed {
      logic [31:0] algorithm_status;
      logic [31:0] measured_motor_values;
      logic [31:0] estimation_status;
   } status_words_s;
endpackage

/* File: status_word_pack.sv */
`timescale 1ns/10ps
// packs core status structs into the three register words
`include "motor_status_params.svh"
module status_word_pack (
   input  wire motor_status_pkg::algorithm_status_s      algo_i,  // algorithm status fields
   input  wire motor_status_pkg::measured_motor_values_s motor_i, // measured motor values
   input  wire motor_status_pkg::estimation_status_s     est_i,   // estimator status
   output motor_status_pkg::status_words_s               words_o  // packed words
);
   always_comb begin
      words_o = '0;
      words_o.algorithm_status[`APPLIED_VOLT_LSB +: 16] = algo_i.applied_voltage_magnitude;
      words_o.algorithm_status[`SPEED_CMD_LSB +: 12] = algo_i.speed_command;
      words_o.algorithm_status[`LOAD_DONE_BIT] = algo_i.startup_load_complete;
      words_o.algorithm_status[`HOST_CTRL_BIT] = algo_i.host_control_allowed;
      words_o.measured_motor_values[`RES_LSB +: 8] = motor_i.winding_resistance;
      words_o.measured_motor_values[`BEMF_LSB +: 8] = motor_i.back_emf_constant;
      words_o.measured_motor_values[`IND_LSB +: 8] = motor_i.winding_inductance;
      words_o.estimation_status[`EST_FLAGS_LSB +: 4] = {est_i.resistance_done,
         est_i.inductance_done, est_i.back_emf_done, est_i.mechanical_done};
      words_o.estimation_status[`EST_RATE_LSB +: 4] = est_i.estimation_switching_rate;
   end
endmodule

/* File: motor_system_status_regs.sv */
`timescale 1ns/10ps
// read-only motor system status register bank
// What this block does
// - voltage magnitude in bits 31-16
// - 12-bit speed command in bits 15-4
// - bit 3 startup load complete flag
// - bit 2 host control allowed flag
// - winding resistance in bits 31-24
// - back-emf constant in bits 23-16
// - inductance bits 15-8, 7-0 reserved
// - all fields read-only, zero after reset
// - estimator status bits 31-28, rate 27-24
//
// read side
//   rd_i and addr_i are taken on one rising edge and the answer follows
//   on the next one. rvalid_o and rerr_o stand for that single cycle;
//   rdata_o keeps the answer until the next read replaces it.
//   reads may come back to back, one per cycle, with no wait state.
//   addr_i is a byte offset; only the three listed offsets decode.
//   an unlisted offset answers zero together with rerr_o, so host
//   software can tell a bad address from a word that reads zero.
//
// update side
//   status_upd_i captures every core field on each clock rising edge where it is high.
//   a read on that same edge returns the older word; the new word is
//   seen from the following edge on, so a read never mixes the two.
//   the core may hold status_upd_i high to track its fields each cycle;
//   it should pulse it when it wants a coherent snapshot.
//   all three words move together; there is no per-word update.
//
// register map
//   e4 algorithm status
//      31-16 applied voltage magnitude, percent = value * 100 / 32768
//      15-4  speed command, percent = value / 4096 * 100
//      3     startup load complete, 0 while stored settings still load
//      2     host control allowed, 0 while defaults are still copied
//      1-0   zero
//   e6 measured motor values
//      31-24 winding resistance
//      23-16 back-emf constant
//      15-8  winding inductance
//      7-0   zero
//   e8 estimation status
//      31    resistance measurement done
//      30    inductance measurement done
//      29    back-emf measurement done
//      28    mechanical measurement done
//      27-24 estimation switching rate code
//      23-0  zero
//   any other offset reads zero and raises rerr_o
//   every word reads zero after reset, reserved ranges included
//
// reserved bits
//   reserved ranges are masked at capture as well as left out by the
//   packer, so a later change of field layout cannot leak stray ones.
//
// limitations
//   there is no write path: the host cannot preset the bank and the
//   core is the only source of values.
//   a read taken on a reset edge is dropped without an answer.
//   scaling of the fields is left to software; the bank stores raw codes.
//   two reads of one word return the same value unless an update edge
//   falls between them.
//
// trade-off
//   whole words are stored rather than bare fields. that costs the flops
//   of the reserved bits, but keeps the read mux a plain or of words and
//   lets one table drive decode, capture and masking alike.
`include "motor_status_params.svh"
module motor_system_status_regs (
   input  wire logic                                  clk_i,        // 50 MHz clock
   input  wire logic                                  rst_i,        // sync reset, active high
   input  wire motor_status_pkg::algorithm_status_s   algo_i,       // core algorithm status
   input  wire motor_status_pkg::measured_motor_values_s motor_i,   // core measured values
   input  wire motor_status_pkg::estimation_status_s  est_i,        // core estimator status
   input  wire logic                                  status_upd_i, // core update strobe
   input  wire logic                                  rd_i,         // read strobe
   input  wire logic [`ADDR_W-1:0]                    addr_i,       // register offset
   output logic [31:0]                                rdata_o,      // read data
   output logic                                       rvalid_o,     // read data valid
   output logic                                       rerr_o        // unmapped offset read
);
   localparam int NUM_WORDS = 3;  // listed words in this group
   localparam int WORD_W    = 32; // width of each status word
   localparam int IDX_ALGO  = 0;  // slot of the algorithm status word
   localparam int IDX_MOTOR = 1;  // slot of the measured motor values
   localparam int IDX_EST   = 2;  // slot of the estimation status word

   // all state in one struct: captured words and the read answer
   typedef struct packed {
      logic [NUM_WORDS-1:0][WORD_W-1:0] words;  // captured snapshot
      logic [WORD_W-1:0]                rdata;  // last read answer
      logic                             rvalid; // answer strobe
      logic                             rerr;   // unmapped offset strobe
   } state_s;

   state_s                            state_reg;    // registered state
   state_s                            state_next;   // its next value
   motor_status_pkg::status_words_s   packed_w;     // core fields, word layout
   logic [NUM_WORDS-1:0][`ADDR_W-1:0] word_ofs_w;   // offset of each word
   logic [NUM_WORDS-1:0][WORD_W-1:0]  word_mask_w;  // live bits of each word
   logic [NUM_WORDS-1:0][WORD_W-1:0]  word_fresh_w; // words from the core
   logic [NUM_WORDS-1:0][WORD_W-1:0]  word_kept_w;  // words after this edge
   logic [NUM_WORDS-1:0]              word_hit_w;   // offset match per word
   logic [WORD_W-1:0]                 word_pick_w;  // selected stored word
   logic                              any_hit_w;    // offset is listed

   // field placement lives in the packer; this file only routes words
   status_word_pack u_pack (
      .algo_i  (algo_i),
      .motor_i (motor_i),
      .est_i   (est_i),
      .words_o (packed_w)
   );

   // bus offset of each listed word
   function automatic logic [`ADDR_W-1:0] word_offset(input int idx);
      case (idx)
         IDX_ALGO: begin
            word_offset = `OFS_ALGORITHM_STATUS;
         end
         IDX_MOTOR: begin
            word_offset = `OFS_MEASURED_MOTOR;
         end
         IDX_EST: begin
            word_offset = `OFS_ESTIMATION;
         end
         default: begin
            word_offset = '0;
         end
      endcase
   endfunction

   // live bits of each word; reserved ranges can never hold a one
   function automatic logic [WORD_W-1:0] word_live_mask(input int idx);
      case (idx)
         IDX_ALGO: begin
            word_live_mask = `ALGO_LIVE_MASK;
         end
         IDX_MOTOR: begin
            word_live_mask = `MOTOR_LIVE_MASK;
         end
         IDX_EST: begin
            word_live_mask = `EST_LIVE_MASK;
         end
         default: begin
            word_live_mask = '0;
         end
      endcase
   endfunction

   // word as the packer lays it out for each slot
   function automatic logic [WORD_W-1:0] word_from_core(
      input int                              idx,
      input motor_status_pkg::status_words_s w
   );
      case (idx)
         IDX_ALGO: begin
            word_from_core = w.algorithm_status;
         end
         IDX_MOTOR: begin
            word_from_core = w.measured_motor_values;
         end
         IDX_EST: begin
            word_from_core = w.estimation_status;
         end
         default: begin
            word_from_core = '0;
         end
      endcase
   endfunction

   // one decode and capture slice per listed word
   for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
      assign word_ofs_w[g]   = word_offset(g);
      assign word_mask_w[g]  = word_live_mask(g);
      assign word_fresh_w[g] = word_from_core(g, packed_w);
      assign word_hit_w[g]   = (addr_i == word_ofs_w[g]);
      // the stored word only moves on an update edge
      assign word_kept_w[g]  = status_upd_i ? (word_fresh_w[g] & word_mask_w[g])
                                            : state_reg.words[g];
   end

   assign any_hit_w = |word_hit_w;

   // offsets are distinct, so at most one slice adds to the pick
   always_comb begin
      word_pick_w = '0;
      for (int i = 0; i < NUM_WORDS; i++) begin
         if (word_hit_w[i]) begin
            word_pick_w = word_pick_w | state_reg.words[i];
         end
      end
   end

   // no write path exists, so unlisted offsets cannot be altered here
   always_comb begin
      state_next        = state_reg;
      state_next.words  = word_kept_w;
      state_next.rvalid = 1'b0;
      state_next.rerr   = 1'b0;
      if (rd_i) begin
         state_next.rvalid = 1'b1;
         if (any_hit_w) begin
            state_next.rdata = word_pick_w;
         end else begin
            state_next.rdata = `RESET_WORD;
            state_next.rerr  = 1'b1;
         end
      end
   end

   // synchronous reset clears every word and strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs come straight from the state flops
   assign rdata_o  = state_reg.rdata;
   assign rvalid_o = state_reg.rvalid;
   assign rerr_o   = state_reg.rerr;
endmodule

/* File: status_bank_properties.sv */
`timescale 1ns/10ps
// read-side checks, motor status bank
module status_bank_checker (
   input wire logic        clk_i,    // clock
   input wire logic        rst_i,    // sync reset
   input wire logic        rd_i,     // read strobe
   input wire logic        rvalid_o, // answer strobe
   input wire logic        rerr_o,   // unmapped offset strobe
   input wire logic [7:0]  addr_i,   // offset
   input wire logic [31:0] rdata_o   // read data
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic hit = addr_i inside {8'he4, 8'he6, 8'he8};
   chk_rd_answer: assert property (rd_i |=> rvalid_o) else $error("no answer");
   chk_no_stray: assert property (!rd_i |=> !(rvalid_o || rerr_o)) else $error("stray");
   chk_hole_err: assert property (rd_i && !hit |=> rerr_o && !rdata_o) else $error("hole");
   chk_mapped_ok: assert property (rd_i && hit |=> !rerr_o) else $error("bad err");
   chk_e4_rsvd: assert property (rd_i && addr_i == 8'he4 |=> !rdata_o[1:0])
      else $error("e4 bits");
   chk_e6_rsvd: assert property (rd_i && addr_i == 8'he6 |=> !rdata_o[7:0])
      else $error("e6 bits");
   chk_e8_rsvd: assert property (rd_i && addr_i == 8'he8 |=> !rdata_o[23:0])
      else $error("e8 bits");
   chk_data_hold: assert property (!rd_i |=> $stable(rdata_o)) else $error("moved");
   cover property (rd_i && addr_i == 8'he6);
   cover property (rd_i && !hit);
   cover property (rd_i ##1 rd_i);
endmodule
bind motor_system_status_regs status_bank_checker chk (.*);

/* File: tb_top.sv */
`timescale 1ns/10ps
// self-checking bench, motor status bank
module tb_top;
   logic clk_i = 0, rst_i = 1, status_upd_i = 0, rd_i = 0, rvalid_o, rerr_o;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] rdata_o;
   logic [32:0] q[$], nt;
   wire [32:0] got = {rerr_o, rdata_o};
   motor_status_pkg::algorithm_status_s algo_i = '0;
   motor_status_pkg::measured_motor_values_s motor_i = '0;
   motor_status_pkg::estimation_status_s est_i = '0;
   int num_errors = 0, n_tests = 0, seed = 20;
   always #10 clk_i = ~clk_i;
   motor_system_status_regs uut (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .algo_i       (algo_i),
      .motor_i      (motor_i),
      .est_i        (est_i),
      .status_upd_i (status_upd_i),
      .rd_i         (rd_i),
      .addr_i       (addr_i),
      .rdata_o      (rdata_o),
      .rvalid_o     (rvalid_o),
      .rerr_o       (rerr_o)
   );
   task automatic close_out;
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      @(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
      q.push_back(e);
   endtask
   // answers come in request order
   always @(negedge clk_i) if (rvalid_o === 1'b1) begin
      nt = q.pop_front();
      n_tests++;
      if (got !== nt) $display("wrong value rdata exp %h got %h", nt, got);
      num_errors += (got !== nt);
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) rd(8'he2 + 8'(i), {!(i inside {2,4,6}), 32'h0});
      for (int k = 0; k < 20; k++) begin
         @(posedge clk_i) {rd_i, status_upd_i, algo_i, motor_i, est_i} <=
            {2'b01, 62'({$random(seed), $random(seed)})};
         @(posedge clk_i) status_upd_i <= 1'b0;
         rd(8'he4, {1'b0, algo_i, 2'h0});
         rd(8'he6, {1'b0, motor_i, 8'h0});
         rd(8'he8, {1'b0, est_i, 24'h0});
         rd(8'($random(seed)) | 8'h01, 33'h100000000);
      end
      @(posedge clk_i) rd_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      num_errors += (q.size() != 0);
      close_out;
   end
   initial begin
      #100000 num_errors++;
      close_out;
   end
endmodule
